//--- verilog/fod_pkg.sv
// Package of opcodes, flag positions and constants for the flag/decode block.
`default_nettype none
package fod_pkg;
    // Flag register bit positions.
    localparam int FL_H = 5;
    localparam int FL_I = 4;
    localparam int FL_N = 3;
    localparam int FL_Z = 2;
    localparam int FL_V = 1;
    localparam int FL_C = 0;
    localparam logic [5:0] FLAGS_RST = 6'h10;
    // Flag manipulation, interrupt return and halt opcodes.
    localparam logic [7:0] OP_CLR_V = 8'h0a;
    localparam logic [7:0] OP_SET_V = 8'h0b;
    localparam logic [7:0] OP_CLR_C = 8'h0c;
    localparam logic [7:0] OP_SET_C = 8'h0d;
    localparam logic [7:0] OP_CLR_I = 8'h0e;
    localparam logic [7:0] OP_SET_I = 8'h0f;
    localparam logic [7:0] OP_A_TO_FL = 8'h06;
    localparam logic [7:0] OP_FL_TO_A = 8'h07;
    localparam logic [7:0] OP_INT_RET = 8'h3b;
    localparam logic [7:0] OP_HALT = 8'h3e;
    // Immediate-to-memory bit operations.
    localparam logic [7:0] OP_AND_IMM_IND = 8'h61;
    localparam logic [7:0] OP_AND_IMM_DIR = 8'h71;
    localparam logic [7:0] OP_OR_IMM_IND = 8'h62;
    localparam logic [7:0] OP_OR_IMM_DIR = 8'h72;
    localparam logic [7:0] OP_XOR_IMM_IND = 8'h65;
    localparam logic [7:0] OP_XOR_IMM_DIR = 8'h75;
    localparam logic [7:0] OP_TST_IMM_IND = 8'h6b;
    localparam logic [7:0] OP_TST_IMM_DIR = 8'h7b;
    // Test values and bit positions for the flag rules, and the halt address.
    localparam logic [7:0] NEG_OVF_VAL = 8'h80;
    localparam logic [7:0] INC_OVF_VAL = 8'h7f;
    localparam logic [3:0] BCD_MAX = 4'h9;
    localparam logic [15:0] HALT_ADDR = 16'hffff;
    localparam int MSB16 = 15;
    localparam int MSB8 = 7;
    // Flag update selection from the execution unit.
    typedef enum logic [3:0] {
        FOD_FU_NONE, FOD_FU_ALU, FOD_FU_NEG, FOD_FU_INC, FOD_FU_SHIFT,
        FOD_FU_W16, FOD_FU_PROD, FOD_FU_DEC_ADJ, FOD_FU_POP
    } fod_fu_t;
endpackage : fod_pkg
`default_nettype wire

//--- verilog/fod_opdec.sv
// Opcode map decoder: flags unassigned codes and classifies operations.
`default_nettype none
module fod_opdec (
    input wire logic [7:0] opcode,
    output logic invalid,
    output logic imm_mem_op
);
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    // Immediate-to-memory ops sit in columns 6 and 7, rows 1, 2, 5, B.
    always_comb begin
        imm_mem_op = (hi == 4'h6 || hi == 4'h7) &&
            (lo == 4'h1 || lo == 4'h2 || lo == 4'h5 || lo == 4'hb);
    end

    always_comb begin
        invalid = 1'b0;
        unique case (hi)
            4'h0: invalid = (lo == 4'h0) || (lo == 4'h2) || (lo == 4'h3);
            4'h1: invalid = (lo == 4'h2) || (lo == 4'h3) ||
                (lo == 4'h4) || (lo == 4'h5) || (lo >= 4'hc);
            4'h2, 4'h3: invalid = 1'b0;
            4'h4, 4'h5: invalid = (lo == 4'h1) || (lo == 4'h2) ||
                (lo == 4'h5) || (lo == 4'hb) || (lo == 4'he);
            4'h6, 4'h7: invalid = 1'b0;
            4'h8: invalid = (lo == 4'h7) || (lo == 4'hf);
            4'hc: invalid = (lo == 4'h7) || (lo == 4'hd) || (lo == 4'hf);
            default: invalid = 1'b0;
        endcase
    end
endmodule : fod_opdec
`default_nettype wire

//--- verilog/fod_flagcalc.sv
// Combinational next-value logic of the flag register.
`default_nettype none
module fod_flagcalc (
    input wire logic [5:0] flags,
    input wire logic [7:0] opcode,
    input wire logic exec,
    input wire logic [7:0] acc_a,
    input wire fod_pkg::fod_fu_t fu_sel,
    input wire logic [5:0] fu_flags,
    input wire logic [7:0] fu_operand,
    input wire logic [15:0] fu_result16,
    input wire logic [7:0] fu_acc_b,
    input wire logic fu_bcd_carry,
    input wire logic [5:0] pop_flags,
    output logic [5:0] flags_next
);
    always_comb begin
        flags_next = flags;
        if (exec) begin
            unique case (opcode)
                fod_pkg::OP_CLR_C: flags_next[fod_pkg::FL_C] = 1'b0;
                fod_pkg::OP_SET_C: flags_next[fod_pkg::FL_C] = 1'b1;
                fod_pkg::OP_CLR_V: flags_next[fod_pkg::FL_V] = 1'b0;
                fod_pkg::OP_SET_V: flags_next[fod_pkg::FL_V] = 1'b1;
                fod_pkg::OP_CLR_I: flags_next[fod_pkg::FL_I] = 1'b0;
                fod_pkg::OP_SET_I: flags_next[fod_pkg::FL_I] = 1'b1;
                fod_pkg::OP_A_TO_FL: flags_next = acc_a[5:0];
                default: flags_next = flags;
            endcase
        end
        unique case (fu_sel)
            fod_pkg::FOD_FU_NONE: ;
            fod_pkg::FOD_FU_ALU: flags_next = fu_flags;
            fod_pkg::FOD_FU_NEG: begin
                flags_next = fu_flags;
                flags_next[fod_pkg::FL_V] =
                    (fu_operand == fod_pkg::NEG_OVF_VAL);
            end
            fod_pkg::FOD_FU_INC: begin
                flags_next = fu_flags;
                flags_next[fod_pkg::FL_V] =
                    (fu_operand == fod_pkg::INC_OVF_VAL);
            end
            fod_pkg::FOD_FU_SHIFT: begin
                flags_next = fu_flags;
                flags_next[fod_pkg::FL_V] = fu_flags[fod_pkg::FL_N] ^
                    fu_flags[fod_pkg::FL_C];
            end
            fod_pkg::FOD_FU_W16: begin
                flags_next = fu_flags;
                flags_next[fod_pkg::FL_N] =
                    fu_result16[fod_pkg::MSB16];
            end
            fod_pkg::FOD_FU_PROD:
                flags_next[fod_pkg::FL_C] = fu_acc_b[fod_pkg::MSB8];
            fod_pkg::FOD_FU_DEC_ADJ: begin
                flags_next = fu_flags;
                flags_next[fod_pkg::FL_C] = flags[fod_pkg::FL_C] |
                    fu_bcd_carry |
                    (fu_operand[7:4] > fod_pkg::BCD_MAX);
            end
            fod_pkg::FOD_FU_POP: flags_next = pop_flags;
            default: ;
        endcase
    end
endmodule : fod_flagcalc
`default_nettype wire

//--- verilog/fod_core.sv
// Flag register, instruction decode and interrupt acceptance control.
// Functional notes
// - While halted: read/write high, address all ones, data drivers off.
// - Flags: H bit 5, I bit 4, N 3, Z 2, V 1, C 0.
// - Flag ops are one-byte one-cycle; decoded from their fixed opcodes.
// - Set and clear flag ops force one flag, others unchanged.
// - Copy A to flags loads every flag bit from A.
// - Interrupt return reloads all flags from the popped value.
// - Decimal adjust sets carry if high digit exceeds nine, never clears it.
// - Negate sets overflow exactly when operand was 80 hex.
// - Increment sets overflow exactly when operand was 7f hex.
// - Shifts and rotates set overflow to N xor C afterwards.
// - Sixteen-bit results take negative from result bit 15.
// - Multiply sets carry from bit 7 of the B half.
// - Leaving halt by interrupt sets the mask; masked halt needs NMI.
// - Unmask then one-cycle op: two instructions run before vectoring.
// - Unmask then longer op: one instruction runs before vectoring.
// - Unmasking via copy A to flags defers interrupts the same way.
// - Immediate-to-memory ops sit in columns 6, 7 of rows 1, 2, 5, B.
`default_nettype none
module fod_core (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] opcode,
    input wire logic op_start,
    input wire logic op_last,
    input wire logic op_one_cycle,
    input wire logic [7:0] acc_a,
    input wire fod_pkg::fod_fu_t fu_sel,
    input wire logic [5:0] fu_flags,
    input wire logic [7:0] fu_operand,
    input wire logic [15:0] fu_result16,
    input wire logic [7:0] fu_acc_b,
    input wire logic fu_bcd_carry,
    input wire logic [5:0] pop_flags,
    input wire logic irq_req,
    input wire logic nmi_req,
    input wire logic [15:0] seq_addr,
    input wire logic seq_rw,
    input wire logic seq_data_oe,
    output logic [5:0] flags,
    output logic [7:0] acc_a_load,
    output logic acc_a_load_en,
    output logic op_invalid,
    output logic op_imm_mem,
    output logic halted,
    output logic take_irq,
    output logic take_nmi,
    output logic [15:0] addr_out,
    output logic rw_out,
    output logic data_oe
);
    // ====================================================================
    // Decode
    // ====================================================================
    logic [5:0] flags_q;
    logic [5:0] flags_d;
    logic flag_op_exec;
    logic is_flag_op;
    logic unmask_now;
    logic halt_q;
    logic halt_masked_q;
    logic [1:0] defer_q;
    logic defer_first_q;
    logic irq_sync1_q;
    logic irq_sync2_q;
    logic nmi_sync1_q;
    logic nmi_sync2_q;
    logic nmi_prev_q;
    logic nmi_edge;
    logic irq_ok;

    fod_opdec u_fod_opdec (
        .opcode(opcode),
        .invalid(op_invalid),
        .imm_mem_op(op_imm_mem)
    );

    // Flag ops complete in their single fetch cycle.
    always_comb begin
        unique case (opcode)
            fod_pkg::OP_CLR_C, fod_pkg::OP_SET_C, fod_pkg::OP_CLR_V,
            fod_pkg::OP_SET_V, fod_pkg::OP_CLR_I, fod_pkg::OP_SET_I,
            fod_pkg::OP_A_TO_FL, fod_pkg::OP_FL_TO_A:
                is_flag_op = 1'b1;
            default: is_flag_op = 1'b0;
        endcase
    end
    assign flag_op_exec = op_start & is_flag_op & ~halt_q;

    // ====================================================================
    // Flag register
    // ====================================================================
    fod_flagcalc u_fod_flagcalc (
        .flags(flags_q),
        .opcode(opcode),
        .exec(flag_op_exec),
        .acc_a(acc_a),
        .fu_sel(fu_sel),
        .fu_flags(fu_flags),
        .fu_operand(fu_operand),
        .fu_result16(fu_result16),
        .fu_acc_b(fu_acc_b),
        .fu_bcd_carry(fu_bcd_carry),
        .pop_flags(pop_flags),
        .flags_next(flags_d)
    );

    // Taking an interrupt always sets the mask, out of halt or not.
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= fod_pkg::FLAGS_RST;
        end else if (take_irq || take_nmi) begin
            flags_q <= flags_d;
            flags_q[fod_pkg::FL_I] <= 1'b1;
        end else begin
            flags_q <= flags_d;
        end
    end
    assign flags = flags_q;

    // Copy flags to A: upper two bits read as one.
    always_ff @(posedge clk) begin
        if (rst) begin
            acc_a_load <= 8'h00;
            acc_a_load_en <= 1'b0;
        end else begin
            acc_a_load <= {2'b11, flags_q};
            acc_a_load_en <= flag_op_exec && (opcode == fod_pkg::OP_FL_TO_A);
        end
    end

    // ====================================================================
    // Interrupt inputs
    // ====================================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_sync1_q <= 1'b0;
            irq_sync2_q <= 1'b0;
            nmi_sync1_q <= 1'b0;
            nmi_sync2_q <= 1'b0;
            nmi_prev_q <= 1'b0;
        end else begin
            irq_sync1_q <= irq_req;
            irq_sync2_q <= irq_sync1_q;
            nmi_sync1_q <= nmi_req;
            nmi_sync2_q <= nmi_sync1_q;
            nmi_prev_q <= nmi_sync2_q;
        end
    end
    assign nmi_edge = nmi_sync2_q & ~nmi_prev_q;

    // ====================================================================
    // Deferred acceptance after unmasking
    // ====================================================================
    // An unmask by the clear op or by copy A to flags opens a window.
    assign unmask_now = flag_op_exec && flags_q[fod_pkg::FL_I] &&
        ((opcode == fod_pkg::OP_CLR_I) ||
         ((opcode == fod_pkg::OP_A_TO_FL) &&
          !acc_a[fod_pkg::FL_I]));

    // Count of instruction boundaries still to pass before vectoring.
    always_ff @(posedge clk) begin
        if (rst) begin
            defer_q <= 2'd0;
            defer_first_q <= 1'b0;
        end else if (unmask_now) begin
            defer_q <= 2'd2;
            defer_first_q <= 1'b1;
        end else if (op_last && defer_q != 2'd0) begin
            defer_first_q <= 1'b0;
            if (defer_first_q && !op_one_cycle) begin
                defer_q <= 2'd0;
            end else begin
                defer_q <= defer_q - 2'd1;
            end
        end
    end

    assign irq_ok = irq_sync2_q && !flags_q[fod_pkg::FL_I] &&
        (defer_q == 2'd0);

    // ====================================================================
    // Halt for interrupt
    // ====================================================================
    always_ff @(posedge clk) begin
        if (rst) begin
            halt_q <= 1'b0;
            halt_masked_q <= 1'b0;
        end else if (halt_q) begin
            if (take_irq || take_nmi) begin
                halt_q <= 1'b0;
            end
        end else if (op_last && opcode == fod_pkg::OP_HALT) begin
            halt_q <= 1'b1;
            halt_masked_q <= flags_q[fod_pkg::FL_I];
        end
    end

    // Masked halt only ends on a non-maskable request.
    assign take_nmi = nmi_edge && (halt_q || op_last);
    assign take_irq = !take_nmi && irq_ok &&
        (halt_q ? !halt_masked_q : op_last);
    assign halted = halt_q;

    always_comb begin
        if (halt_q) begin
            addr_out = fod_pkg::HALT_ADDR;
            rw_out = 1'b1;
            data_oe = 1'b0;
        end else begin
            addr_out = seq_addr;
            rw_out = seq_rw;
            data_oe = seq_data_oe;
        end
    end

    // ====================================================================
    // Checks
    // ====================================================================
    a_halt_bus: assert property (@(posedge clk) disable iff (rst)
        halt_q |-> (addr_out == 16'hffff && rw_out && !data_oe))
        else $error("halt bus state wrong");
    a_clr_carry: assert property (@(posedge clk) disable iff (rst)
        (flag_op_exec && opcode == 8'h0c && fu_sel == fod_pkg::FOD_FU_NONE
         && !take_irq && !take_nmi) |=> !flags_q[0])
        else $error("clear carry failed");
    a_set_ovf: assert property (@(posedge clk) disable iff (rst)
        (flag_op_exec && opcode == 8'h0b && fu_sel == fod_pkg::FOD_FU_NONE)
        |=> flags_q[1] && $stable(flags_q[0]))
        else $error("set overflow failed");
    a_a_to_flags: assert property (@(posedge clk) disable iff (rst)
        (flag_op_exec && opcode == 8'h06 && fu_sel == fod_pkg::FOD_FU_NONE
         && !take_irq && !take_nmi) |=> flags_q == $past(acc_a[5:0]))
        else $error("copy A to flags failed");
    a_neg_ovf: assert property (@(posedge clk) disable iff (rst)
        (fu_sel == fod_pkg::FOD_FU_NEG) |=>
        flags_q[1] == ($past(fu_operand) == 8'h80))
        else $error("negate overflow wrong");
    a_inc_ovf: assert property (@(posedge clk) disable iff (rst)
        (fu_sel == fod_pkg::FOD_FU_INC) |=>
        flags_q[1] == ($past(fu_operand) == 8'h7f))
        else $error("increment overflow wrong");
    a_prod_carry: assert property (@(posedge clk) disable iff (rst)
        (fu_sel == fod_pkg::FOD_FU_PROD) |=>
        flags_q[0] == $past(fu_acc_b[7]))
        else $error("multiply carry wrong");
    a_irq_sets_mask: assert property (@(posedge clk)
        disable iff (rst) take_irq |=> flags_q[4])
        else $error("mask not set on interrupt");
    a_defer_block: assert property (@(posedge clk) disable iff (rst)
        unmask_now |=> !take_irq)
        else $error("interrupt taken right after unmask");
    a_masked_halt: assert property (@(posedge clk) disable iff (rst)
        (halt_q && halt_masked_q) |-> !take_irq)
        else $error("masked halt left by maskable request");
    c_halt_exit: cover property (@(posedge clk) halt_q && take_irq);
    c_nmi_exit: cover property (@(posedge clk) halt_q && take_nmi);
    c_defer: cover property (@(posedge clk) unmask_now ##[1:20] take_irq);
    c_invalid: cover property (@(posedge clk) op_start && op_invalid);
endmodule : fod_core
`default_nettype wire

//--- tb/test_flag_ops_and_opcode_decode.sv
// Self-checking bench for the flag register and opcode decode block.
`default_nettype none
module test_flag_ops_and_opcode_decode;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [2:0] sel;
        logic [23:0] mask;
        logic [23:0] exp;
    } fod_note_t;
    logic clk = 1'b0;
    logic rst;
    logic [7:0] opcode, acc_a, fu_operand, fu_acc_b, acc_a_load;
    logic op_start, op_last, op_one_cycle, fu_bcd_carry, irq_req, nmi_req;
    logic seq_rw, seq_data_oe, probe, acc_a_load_en, op_invalid, op_imm_mem;
    logic halted, take_irq, take_nmi, rw_out, data_oe;
    logic [5:0] fu_flags, pop_flags, flags;
    logic [15:0] fu_result16, seq_addr, addr_out;
    fod_pkg::fod_fu_t fu_sel;
    fod_note_t notes[$];
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] fops [6] = '{fod_pkg::OP_CLR_V, fod_pkg::OP_SET_V,
        fod_pkg::OP_CLR_C, fod_pkg::OP_SET_C, fod_pkg::OP_CLR_I,
        fod_pkg::OP_SET_I};
    logic [7:0] dops [16] = '{8'h61, 8'h71, 8'h62, 8'h72, 8'h65, 8'h75,
        8'h6b, 8'h7b, 8'h60, 8'h70, 8'h19, 8'h00, 8'h12, 8'h87, 8'hcf, 8'h41};

    always #4 clk = ~clk;

    fod_core u_fod_core (.clk(clk), .rst(rst), .opcode(opcode),
        .op_start(op_start), .op_last(op_last), .op_one_cycle(op_one_cycle),
        .acc_a(acc_a), .fu_sel(fu_sel), .fu_flags(fu_flags),
        .fu_operand(fu_operand), .fu_result16(fu_result16),
        .fu_acc_b(fu_acc_b), .fu_bcd_carry(fu_bcd_carry),
        .pop_flags(pop_flags), .irq_req(irq_req), .nmi_req(nmi_req),
        .seq_addr(seq_addr), .seq_rw(seq_rw), .seq_data_oe(seq_data_oe),
        .flags(flags), .acc_a_load(acc_a_load), .acc_a_load_en(acc_a_load_en),
        .op_invalid(op_invalid), .op_imm_mem(op_imm_mem), .halted(halted),
        .take_irq(take_irq), .take_nmi(take_nmi), .addr_out(addr_out),
        .rw_out(rw_out), .data_oe(data_oe));

    // =========================================================
    // Drivers and result checking
    // =========================================================
    task automatic cyc(input int n = 1);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic step(input logic [7:0] op, input logic st,
                        input logic lst, input logic one);
        opcode = op;
        op_start = st;
        op_last = lst;
        op_one_cycle = one;
    endtask : step

    // Queues the expectation for the current cycle and lets one cycle pass.
    task automatic note(input logic [2:0] s, input logic [23:0] m,
                        input logic [23:0] e);
        fod_note_t t;
        t.sel = s;
        t.mask = m;
        t.exp = e;
        notes.push_back(t);
        probe = 1'b1;
        cyc();
        probe = 1'b0;
    endtask : note

    task automatic flag_op(input logic [7:0] op);
        step(op, 1'b1, 1'b1, 1'b1);
        cyc();
        step(op, 1'b0, 1'b0, 1'b1);
    endtask : flag_op

    // The halt op is a multi-cycle instruction.
    task automatic halt_op();
        step(fod_pkg::OP_HALT, 1'b1, 1'b1, 1'b0);
        cyc();
        step(fod_pkg::OP_HALT, 1'b0, 1'b0, 1'b1);
    endtask : halt_op

    task automatic fu(input fod_pkg::fod_fu_t k);
        fu_sel = k;
        cyc();
        fu_sel = fod_pkg::FOD_FU_NONE;
    endtask : fu

    task automatic reset_dut();
        rst = 1'b1;
        irq_req = 1'b0;
        nmi_req = 1'b0;
        fu_sel = fod_pkg::FOD_FU_NONE;
        step(8'h01, 1'b0, 1'b0, 1'b1);
        cyc(16);
        rst = 1'b0;
    endtask : reset_dut

    task automatic wait_run();
        for (int k = 0; k < 12 && halted !== 1'b0; k++) cyc();
    endtask : wait_run

    // Runs instructions after unmasking and expects the vector on the last.
    task automatic irq_defer(input logic [7:0] unmask, input logic one);
        int n;
        n = one ? 3 : 2;
        reset_dut();
        acc_a = 8'h00;
        irq_req = 1'b1;
        cyc(4);
        step(unmask, 1'b1, 1'b1, 1'b1);
        cyc();
        for (int k = 0; k < n; k++) begin
            if (!one) begin
                step(8'h96, 1'b1, 1'b0, 1'b0);
                cyc();
            end
            step(one ? 8'h01 : 8'h96, one, 1'b1, one);
            note(3'h3, 24'h4, {21'h0, k == n - 1, 2'b0});
        end
    endtask : irq_defer

    function automatic logic [23:0] obs(input logic [2:0] s);
        case (s)
            3'h0: obs = {18'h0, flags};
            3'h1: obs = {22'h0, op_invalid, op_imm_mem};
            3'h2: obs = {6'h0, addr_out, rw_out, data_oe};
            3'h3: obs = {21'h0, take_irq, take_nmi, halted};
            default: obs = {15'h0, acc_a_load_en, acc_a_load};
        endcase
    endfunction : obs

    task automatic check(input logic [23:0] seen, input logic [23:0] want);
        check_count++;
        if (seen !== want) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check

    always @(negedge clk) begin
        if (probe === 1'b1) begin
            fod_note_t t;
            t = notes.pop_front();
            check(obs(t.sel) & t.mask, t.exp & t.mask);
        end
    end

    task automatic results();
        $display("checks=%0d mismatches=%0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : results

    initial begin
        #(5000 * 8);
        n_errors++;
        results();
    end

    // =========================================================
    // Test sequence
    // =========================================================
    initial begin
        logic [5:0] f;
        logic [7:0] r;
        int j;
        probe = 1'b0;
        acc_a = 8'h00;
        fu_flags = 6'h00;
        fu_operand = 8'h00;
        fu_result16 = 16'h0000;
        fu_acc_b = 8'h00;
        fu_bcd_carry = 1'b0;
        pop_flags = 6'h00;
        seq_addr = 16'h0000;
        seq_rw = 1'b1;
        seq_data_oe = 1'b0;
        void'($urandom(32'h8100));
        reset_dut();
        note(3'h0, 24'h3f, 24'h10);
        for (int i = 0; i < 12; i++) begin
            j = i % 6;
            r = 8'($urandom());
            acc_a = r;
            flag_op(fod_pkg::OP_A_TO_FL);
            note(3'h0, 24'h3f, {18'h0, r[5:0]});
            flag_op(fops[j]);
            f = r[5:0];
            f[j < 2 ? fod_pkg::FL_V : j < 4 ? fod_pkg::FL_C :
              fod_pkg::FL_I] = j[0];
            note(3'h0, 24'h3f, {18'h0, f});
        end
        flag_op(fod_pkg::OP_FL_TO_A);
        note(3'h4, 24'h1ff, {15'h0, 3'b111, f});
        note(3'h4, 24'h100, 24'h0);
        $display("done: flag operations");
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 8'h80 : (i == 1) ? 8'h7f : 8'($urandom());
            fu_operand = r;
            fu_flags = 6'($urandom());
            fu(fod_pkg::FOD_FU_NEG);
            note(3'h0, 24'h02, {22'h0, r == 8'h80, 1'b0});
            fu(fod_pkg::FOD_FU_INC);
            note(3'h0, 24'h02, {22'h0, r == 8'h7f, 1'b0});
            fu(fod_pkg::FOD_FU_SHIFT);
            note(3'h0, 24'h02, {22'h0, fu_flags[3] ^ fu_flags[0], 1'b0});
            fu_result16 = 16'($urandom());
            fu(fod_pkg::FOD_FU_W16);
            note(3'h0, 24'h08, {20'h0, fu_result16[15], 3'h0});
            fu_acc_b = 8'($urandom());
            fu(fod_pkg::FOD_FU_PROD);
            note(3'h0, 24'h01, {23'h0, fu_acc_b[7]});
            pop_flags = 6'($urandom());
            fu(fod_pkg::FOD_FU_POP);
            note(3'h0, 24'h3f, {18'h0, pop_flags});
        end
        for (int i = 0; i < 3; i++) begin
            flag_op(i == 0 ? fod_pkg::OP_SET_C : fod_pkg::OP_CLR_C);
            fu_operand = (i == 0) ? 8'h12 : (i == 1) ? 8'ha0 : 8'h90;
            fu(fod_pkg::FOD_FU_DEC_ADJ);
            note(3'h0, 24'h01, {23'h0, i != 2});
        end
        $display("done: flag updates");
        for (int i = 0; i < 16; i++) begin
            opcode = dops[i];
            note(3'h1, 24'h3, i < 8 ? 24'h1 : i < 11 ? 24'h0 : 24'h2);
        end
        $display("done: opcode map");
        irq_defer(fod_pkg::OP_CLR_I, 1'b1);
        irq_defer(fod_pkg::OP_CLR_I, 1'b0);
        irq_defer(fod_pkg::OP_A_TO_FL, 1'b1);
        $display("done: deferred interrupts");
        reset_dut();
        seq_addr = 16'($urandom());
        seq_rw = 1'b0;
        seq_data_oe = 1'b1;
        note(3'h2, 24'h3ffff, {6'h0, seq_addr, 2'b01});
        irq_req = 1'b1;
        halt_op();
        note(3'h2, 24'h3ffff, {6'h0, 16'hffff, 2'b10});
        flag_op(fod_pkg::OP_SET_C);
        cyc(6);
        note(3'h0, 24'h3f, 24'h10);
        note(3'h3, 24'h7, 24'h1);
        nmi_req = 1'b1;
        cyc(2);
        note(3'h3, 24'h7, 24'h3);
        wait_run();
        note(3'h3, 24'h1, 24'h0);
        note(3'h0, 24'h10, 24'h10);
        reset_dut();
        flag_op(fod_pkg::OP_CLR_I);
        cyc();
        halt_op();
        note(3'h3, 24'h1, 24'h1);
        irq_req = 1'b1;
        cyc(2);
        note(3'h3, 24'h7, 24'h5);
        wait_run();
        note(3'h3, 24'h1, 24'h0);
        note(3'h0, 24'h10, 24'h10);
        $display("done: halt for interrupt");
        results();
    end
endmodule : test_flag_ops_and_opcode_decode
`default_nettype wire
